// *** hw/pss_pkg.sv ***
package pss_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;
    localparam int unsigned UFRAME_NS       = 125_000;
    localparam int unsigned UFRAME_CYC      = UFRAME_NS / CLK_NS;
    localparam int unsigned FRAME_NS        = 1_000_000;
    localparam int unsigned FRAME_CYC       = FRAME_NS / CLK_NS;
    localparam int unsigned IDLE_NS         = 250_000;
    localparam int unsigned IDLE_CYC        = IDLE_NS / CLK_NS;
    // issue window inside a microframe, in cycles after the marker and before the next
    localparam int unsigned TOK_GAP_CYC     = 20;
    localparam int unsigned TOK_GUARD_CYC   = 20;

    // frame structure and budget
    localparam logic [2:0]  UF_LAST         = 3'h7;
    localparam logic [2:0]  UF_Y6           = 3'h6;
    localparam logic [2:0]  UF_Y0           = 3'h0;
    localparam int unsigned FS_BYTES_PER_UF = 188;
    localparam int unsigned SS_PER_UF_MAX   = 16;
    localparam int unsigned PROTO_OVH_BYTES = 10;
    localparam int unsigned THINK_LSB       = 5;
    localparam int unsigned THINK_MSB       = 6;

    // reset values
    localparam logic [10:0] FRAME_RST       = 11'h000;
    localparam logic [2:0]  UF_RST          = 3'h7;

    typedef enum logic [1:0] {KIND_ISO_OUT, KIND_ISO_IN, KIND_INT} pss_kind_t;
    typedef enum logic [1:0] {POS_ALL, POS_BEGIN, POS_MID, POS_END} pss_pos_t;
    typedef enum logic [1:0] {ANS_ACK, ANS_NYET, ANS_ERR, ANS_STALL} pss_ans_t;

endpackage : pss_pkg

// *** hw/pss_link_if.sv ***
`timescale 1ns/10ps
interface pss_link_if;
    logic                 sof_vld;
    logic [10:0]          sof_frame;
    logic                 tok_vld;
    logic                 tok_cs;
    pss_pkg::pss_kind_t   tok_kind;
    pss_pkg::pss_pos_t    tok_pos;
    logic [9:0]           tok_len;
    logic                 ans_vld;
    pss_pkg::pss_ans_t    ans_code;

    modport host (output sof_vld, sof_frame, tok_vld, tok_cs, tok_kind, tok_pos, tok_len,
                  input  ans_vld, ans_code);
    modport xlat (input  sof_vld, sof_frame, tok_vld, tok_cs, tok_kind, tok_pos, tok_len,
                  output ans_vld, ans_code);
endinterface : pss_link_if

// *** hw/pss_host.sv ***
// How it works
// - eight numbered microframes per frame, restarting
// - budget assumes 188 bytes per microframe
// - start-split one microframe early, completes after
// - budget adds payload, gaps, think time
// - translator locks timer to frame changes
// - translator stops frame markers after idle
// - frame marker tracks zeroth microframe marker
// - splits only inside their scheduled microframe
// - no first start-split in microframe six; iso out pieces can reach it
// - iso out: one 188-byte piece per microframe
// - iso out pieces carry position codes
// - zero-length iso out only as all
// - other kinds: single start-split ahead
// - at most one complete-split per microframe, besides retries
// - no complete-split for iso out
// - interrupt: two or three complete-splits
// - iso in: complete after each, plus two
// - iso in, last six: seven, and zero unless start is zero
// - iso in, last seven: next zero unless start is zero
// - at most 16 start-splits per microframe
// - retry complete-split at once after error
// - completes keep start-split order
`timescale 1ns/10ps
module pss_host (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               srst,
    // link to the speed_translator
    pss_link_if.host                link,
    // user request
    input  wire logic               run,
    input  wire logic               req_vld,
    output logic                    req_ready,
    input  wire pss_pkg::pss_kind_t req_kind,
    input  wire logic [2:0]         req_start_uf,
    input  wire logic [9:0]         req_len,
    input  wire logic [15:0]        hub_traits_field,
    input  wire logic               hs_err,
    // user status
    output logic                    busy,
    output logic                    done,
    output logic                    refused,
    output logic [10:0]             cur_frame,
    output logic [2:0]              cur_uf
);

    typedef enum {ST_IDLE, ST_WAIT, ST_RUN, ST_ANS} pss_hst_t;

    pss_hst_t           st_q, st_d;
    logic [10:0]        cnt_q, cnt_d;
    logic [2:0]         uf_q, uf_d;
    logic [10:0]        frame_q, frame_d;
    logic               sof_q, sof_d;
    logic               tok_q, tok_d;
    logic               tcs_q, tcs_d;
    pss_pkg::pss_kind_t kind_q, kind_d;
    pss_pkg::pss_pos_t  pos_q, pos_d;
    logic [9:0]         tlen_q, tlen_d;
    logic [2:0]         s_q, s_d;
    logic [9:0]         rem_q, rem_d;
    logic [3:0]         pcs_q, pcs_d;
    logic [15:0]        ssm_q, ssm_d;
    logic [15:0]        csm_q, csm_d;
    logic [3:0]         last_q, last_d;
    logic [3:0]         slot_q, slot_d;
    logic               pend_q, pend_d;
    logic [4:0]         ssc_q, ssc_d;
    logic               done_q, done_d;
    logic               ref_q, ref_d;

    // schedule worked out from the request
    logic [11:0]        total;
    logic [3:0]         nmf;
    logic [3:0]         pcs;
    logic [2:0]         lst;
    logic [15:0]        ssm;
    logic [15:0]        csm;
    logic [3:0]         last;
    logic               tick;
    logic               win;

    // best case budget, no bit stuffing counted
    always_comb
    begin
        total = 12'(req_len) + 12'(pss_pkg::PROTO_OVH_BYTES)
              + 12'(hub_traits_field[pss_pkg::THINK_MSB:pss_pkg::THINK_LSB]) + 12'h001;
        nmf = 4'h1;
        pcs = 4'h1;
        for (int j = 1; j < 8; j++)
        begin
            if (total > 12'(j * pss_pkg::FS_BYTES_PER_UF))
                nmf = nmf + 4'h1;
            if (12'(req_len) > 12'(j * pss_pkg::FS_BYTES_PER_UF))
                pcs = pcs + 4'h1;
        end
        lst = 3'(req_start_uf + nmf[2:0]);
        ssm = 16'h0000;
        csm = 16'h0000;
        unique case (req_kind)
            pss_pkg::KIND_ISO_OUT:
            begin
                for (int t = 0; t < 8; t++)
                    if (t < int'(pcs))
                        ssm[t] = 1'b1;
            end
            pss_pkg::KIND_INT:
            begin
                ssm[0] = 1'b1;
                csm[2] = 1'b1;
                csm[3] = 1'b1;
                csm[4] = (req_start_uf != pss_pkg::UF_Y6);
            end
            default:
            begin
                ssm[0] = 1'b1;
                for (int t = 2; t < 10; t++)
                    if (t <= int'(nmf) + 1)
                        csm[t] = 1'b1;
                if (lst < pss_pkg::UF_Y6)
                begin
                    csm[int'(nmf) + 2] = 1'b1;
                    csm[int'(nmf) + 3] = 1'b1;
                end
                else if (lst == pss_pkg::UF_Y6)
                begin
                    csm[int'(nmf) + 2] = 1'b1;
                    csm[int'(nmf) + 3] = (req_start_uf != pss_pkg::UF_Y0);
                end
                else
                    csm[int'(nmf) + 2] = (req_start_uf != pss_pkg::UF_Y0);
            end
        endcase
        last = 4'h0;
        for (int t = 0; t < 16; t++)
            if (ssm[t] | csm[t])
                last = 4'(t);
    end

    // a token never starts near a microframe edge
    assign tick = (cnt_q == 11'(pss_pkg::UFRAME_CYC - 1));
    assign win  = (cnt_q >= 11'(pss_pkg::TOK_GAP_CYC))
               && (cnt_q < 11'(pss_pkg::UFRAME_CYC - pss_pkg::TOK_GUARD_CYC));
    assign req_ready = (st_q == ST_IDLE);

    // microframe timer, markers and scheduler
    always_comb
    begin
        cnt_d   = tick ? 11'h000 : cnt_q + 11'h001;
        uf_d    = uf_q;
        frame_d = frame_q;
        sof_d   = 1'b0;
        tok_d   = 1'b0;
        tcs_d   = tcs_q;
        kind_d  = kind_q;
        pos_d   = pos_q;
        tlen_d  = tlen_q;
        s_d     = s_q;
        rem_d   = rem_q;
        pcs_d   = pcs_q;
        ssm_d   = ssm_q;
        csm_d   = csm_q;
        last_d  = last_q;
        slot_d  = slot_q;
        pend_d  = pend_q;
        ssc_d   = tick ? 5'h00 : ssc_q;
        done_d  = 1'b0;
        ref_d   = 1'b0;
        st_d    = st_q;
        if (tick && run)
        begin
            uf_d    = uf_q + 3'h1;
            frame_d = (uf_q == pss_pkg::UF_LAST) ? frame_q + 11'h001 : frame_q;
            sof_d   = 1'b1;
        end
        unique case (st_q)
            ST_IDLE:
            begin
                if (req_vld)
                begin
                    if (req_start_uf == pss_pkg::UF_LAST)
                        ref_d = 1'b1;
                    else
                    begin
                        kind_d = req_kind;
                        s_d    = req_start_uf;
                        rem_d  = req_len;
                        pcs_d  = pcs;
                        ssm_d  = ssm;
                        csm_d  = csm;
                        last_d = last;
                        st_d   = ST_WAIT;
                    end
                end
            end
            ST_WAIT:
            begin
                if (sof_d && uf_d == 3'(s_q - 3'h1))
                begin
                    slot_d = 4'h0;
                    pend_d = ssm_q[0] | csm_q[0];
                    st_d   = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (tick)
                begin
                    done_d = (slot_q == last_q);
                    st_d   = done_d ? ST_IDLE : ST_RUN;
                    slot_d = slot_q + 4'h1;
                    pend_d = ssm_q[slot_d] | csm_q[slot_d];
                end
                else if (pend_q && win && run)
                begin
                    if (ssm_q[slot_q])
                    begin
                        if (ssc_q < 5'(pss_pkg::SS_PER_UF_MAX))
                        begin
                            tok_d  = 1'b1;
                            tcs_d  = 1'b0;
                            ssc_d  = ssc_q + 5'h01;
                            pend_d = 1'b0;
                            if (kind_q != pss_pkg::KIND_ISO_OUT || pcs_q == 4'h1)
                                pos_d = pss_pkg::POS_ALL;
                            else if (slot_q == 4'h0)
                                pos_d = pss_pkg::POS_BEGIN;
                            else if (slot_q == pcs_q - 4'h1)
                                pos_d = pss_pkg::POS_END;
                            else
                                pos_d = pss_pkg::POS_MID;
                            if (kind_q == pss_pkg::KIND_ISO_OUT && slot_q != pcs_q - 4'h1)
                                tlen_d = 10'(pss_pkg::FS_BYTES_PER_UF);
                            else
                                tlen_d = rem_q;
                            if (kind_q == pss_pkg::KIND_ISO_OUT)
                                rem_d = rem_q - tlen_d;
                        end
                    end
                    else
                    begin
                        tok_d  = 1'b1;
                        tcs_d  = 1'b1;
                        pos_d  = pss_pkg::POS_ALL;
                        tlen_d = rem_q;
                        pend_d = 1'b0;
                        st_d   = ST_ANS;
                    end
                end
            end
            ST_ANS:
            begin
                if (link.ans_vld)
                begin
                    pend_d = (link.ans_code == pss_pkg::ANS_ERR) || hs_err;
                    done_d = !pend_d && (link.ans_code == pss_pkg::ANS_ACK);
                    st_d   = done_d ? ST_IDLE : ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            st_q    <= ST_IDLE;
            cnt_q   <= 11'h000;
            uf_q    <= pss_pkg::UF_RST;
            frame_q <= pss_pkg::FRAME_RST;
            sof_q   <= 1'b0;
            tok_q   <= 1'b0;
            tcs_q   <= 1'b0;
            kind_q  <= pss_pkg::KIND_ISO_OUT;
            pos_q   <= pss_pkg::POS_ALL;
            tlen_q  <= 10'h000;
            s_q     <= 3'h0;
            rem_q   <= 10'h000;
            pcs_q   <= 4'h0;
            ssm_q   <= 16'h0000;
            csm_q   <= 16'h0000;
            last_q  <= 4'h0;
            slot_q  <= 4'h0;
            pend_q  <= 1'b0;
            ssc_q   <= 5'h00;
            done_q  <= 1'b0;
            ref_q   <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            uf_q    <= uf_d;
            frame_q <= frame_d;
            sof_q   <= sof_d;
            tok_q   <= tok_d;
            tcs_q   <= tcs_d;
            kind_q  <= kind_d;
            pos_q   <= pos_d;
            tlen_q  <= tlen_d;
            s_q     <= s_d;
            rem_q   <= rem_d;
            pcs_q   <= pcs_d;
            ssm_q   <= ssm_d;
            csm_q   <= csm_d;
            last_q  <= last_d;
            slot_q  <= slot_d;
            pend_q  <= pend_d;
            ssc_q   <= ssc_d;
            done_q  <= done_d;
            ref_q   <= ref_d;
        end
    end

    // link and status outputs, all from flops
    assign link.sof_vld   = sof_q;
    assign link.sof_frame = frame_q;
    assign link.tok_vld   = tok_q;
    assign link.tok_cs    = tcs_q;
    assign link.tok_kind  = kind_q;
    assign link.tok_pos   = pos_q;
    assign link.tok_len   = tlen_q;
    assign busy           = (st_q != ST_IDLE);
    assign done           = done_q;
    assign refused        = ref_q;
    assign cur_frame      = frame_q;
    assign cur_uf         = uf_q;

endmodule : pss_host

// *** hw/pss_xlat.sv ***
`timescale 1ns/10ps
module pss_xlat #(
    parameter int unsigned FRAME_CYC = pss_pkg::FRAME_CYC
) (
    // clock and reset
    input  wire logic   clock,
    input  wire logic   srst,
    // link from the host
    pss_link_if.xlat    link,
    // downstream full-speed side
    output logic        fs_sof,
    output logic [10:0] fs_frame,
    output logic [2:0]  uframe,
    output logic        locked,
    output logic        hs_idle,
    output logic        ss_seen,
    // protocol violations seen from the host
    output logic        err_ss_y6,
    output logic        err_ss_many,
    output logic        err_cs_iso_out
);

    logic [10:0] prev_q, prev_d;
    logic        have_q, have_d;
    logic [2:0]  uf_q, uf_d;
    logic        lock_q, lock_d;
    logic [13:0] ft_q, ft_d;
    logic [11:0] idle_q, idle_d;
    logic [4:0]  ssc_q, ssc_d;
    logic        fsof_q, fsof_d;
    logic [10:0] ffr_q, ffr_d;
    logic        ssn_q, ssn_d;
    logic        e6_q, e6_d;
    logic        em_q, em_d;
    logic        ec_q, ec_d;
    logic        av_q, av_d;
    pss_pkg::pss_ans_t ac_q, ac_d;
    logic        idle;
    logic        zeroth;

    assign idle   = (idle_q >= 12'(pss_pkg::IDLE_CYC));
    assign zeroth = link.sof_vld && have_q && (link.sof_frame != prev_q);

    // frame timer locked to microframe markers
    always_comb
    begin
        prev_d = link.sof_vld ? link.sof_frame : prev_q;
        have_d = have_q | link.sof_vld;
        uf_d   = uf_q;
        lock_d = lock_q;
        ft_d   = (ft_q == 14'(FRAME_CYC - 1)) ? 14'h0000 : ft_q + 14'h0001;
        fsof_d = 1'b0;
        ffr_d  = ffr_q;
        ssc_d  = ssc_q;
        // any link traffic counts as activity; counter saturates
        if (link.sof_vld || link.tok_vld)
            idle_d = 12'h000;
        else
            idle_d = idle ? idle_q : idle_q + 12'h001;
        if (zeroth)
        begin
            uf_d   = 3'h0;
            ft_d   = 14'h0000;
            lock_d = 1'b1;
            fsof_d = 1'b1;
            ffr_d  = link.sof_frame;
        end
        else if (link.sof_vld)
            uf_d = (uf_q == pss_pkg::UF_LAST) ? uf_q : uf_q + 3'h1;
        else if (lock_q && !idle && ft_q == 14'(FRAME_CYC - 1))
        begin
            fsof_d = 1'b1;
            ffr_d  = ffr_q + 11'h001;
        end
        if (link.sof_vld)
            ssc_d = 5'h00;
        if (idle)
            lock_d = 1'b0;
        // answers and checks on tokens
        av_d  = link.tok_vld;
        ac_d  = pss_pkg::ANS_ACK;
        ssn_d = 1'b0;
        e6_d  = 1'b0;
        em_d  = 1'b0;
        ec_d  = 1'b0;
        if (link.tok_vld && !link.tok_cs)
        begin
            ssn_d = 1'b1;
            ssc_d = (ssc_q == 5'h1f) ? ssc_q : ssc_q + 5'h01;
            e6_d  = (uf_q == pss_pkg::UF_Y6);
            em_d  = (ssc_q >= 5'(pss_pkg::SS_PER_UF_MAX));
        end
        else if (link.tok_vld)
        begin
            ec_d = (link.tok_kind == pss_pkg::KIND_ISO_OUT);
            ac_d = ec_d ? pss_pkg::ANS_STALL : pss_pkg::ANS_NYET;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            prev_q <= pss_pkg::FRAME_RST;
            have_q <= 1'b0;
            uf_q   <= pss_pkg::UF_RST;
            lock_q <= 1'b0;
            ft_q   <= 14'h0000;
            idle_q <= 12'h000;
            ssc_q  <= 5'h00;
            fsof_q <= 1'b0;
            ffr_q  <= pss_pkg::FRAME_RST;
            ssn_q  <= 1'b0;
            e6_q   <= 1'b0;
            em_q   <= 1'b0;
            ec_q   <= 1'b0;
            av_q   <= 1'b0;
            ac_q   <= pss_pkg::ANS_ACK;
        end
        else
        begin
            prev_q <= prev_d;
            have_q <= have_d;
            uf_q   <= uf_d;
            lock_q <= lock_d;
            ft_q   <= ft_d;
            idle_q <= idle_d;
            ssc_q  <= ssc_d;
            fsof_q <= fsof_d;
            ffr_q  <= ffr_d;
            ssn_q  <= ssn_d;
            e6_q   <= e6_d;
            em_q   <= em_d;
            ec_q   <= ec_d;
            av_q   <= av_d;
            ac_q   <= ac_d;
        end
    end

    assign link.ans_vld  = av_q;
    assign link.ans_code = ac_q;
    assign fs_sof         = fsof_q;
    assign fs_frame       = ffr_q;
    assign uframe         = uf_q;
    assign locked         = lock_q;
    assign hs_idle        = idle;
    assign ss_seen        = ssn_q;
    assign err_ss_y6      = e6_q;
    assign err_ss_many    = em_q;
    assign err_cs_iso_out = ec_q;

endmodule : pss_xlat

// *** verif/pss_chk.sv ***
`timescale 1ns/10ps
module pss_chk (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               srst,
    // microframe markers
    input  wire logic               sof_vld,
    input  wire logic [10:0]        sof_frame,
    // split tokens and answers
    input  wire logic               tok_vld,
    input  wire logic               tok_cs,
    input  wire pss_pkg::pss_kind_t tok_kind,
    input  wire pss_pkg::pss_pos_t  tok_pos,
    input  wire logic [9:0]         tok_len,
    input  wire logic               ans_vld,
    input  wire pss_pkg::pss_ans_t  ans_code
);
    logic [2:0]        uf_q, uf_d;
    logic [10:0]       frm_q, frm_d;
    logic [15:0]       cnt_q, cnt_d;
    pss_pkg::pss_pos_t pos_q, pos_d;
    logic              ss, iso_ss;

    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    assign ss = tok_vld && !tok_cs;
    assign iso_ss = ss && (tok_kind == pss_pkg::KIND_ISO_OUT);

    // shadow microframe, frame, cycle; cycle count saturates
    always_comb
    begin
        uf_d  = sof_vld ? uf_q + 3'h1 : uf_q;
        frm_d = sof_vld ? sof_frame : frm_q;
        cnt_d = sof_vld ? 16'h0001 : ((cnt_q == 16'hffff) ? cnt_q : cnt_q + 16'h0001);
        pos_d = iso_ss ? tok_pos : pos_q;
    end

    // reset mirrors the host; position starts at end
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            uf_q  <= pss_pkg::UF_RST;
            frm_q <= pss_pkg::FRAME_RST;
            cnt_q <= 16'h0000;
            pos_q <= pss_pkg::POS_END;
        end
        else
        begin
            uf_q  <= uf_d;
            frm_q <= frm_d;
            cnt_q <= cnt_d;
            pos_q <= pos_d;
        end
    end

    sequence s_ack;
        ans_vld && (ans_code == pss_pkg::ANS_ACK);
    endsequence
    sequence s_mid_or_end;
        iso_ss && (tok_pos == pss_pkg::POS_MID || tok_pos == pss_pkg::POS_END);
    endsequence

    property p_ss_ack;
        ss |=> s_ack;
    endproperty
    property p_uf_num;
        sof_vld |-> ((sof_frame != frm_q) == (uf_q == pss_pkg::UF_LAST));
    endproperty
    property p_window;
        tok_vld |-> (cnt_q >= 16'h0014) && (cnt_q <= 16'h04ce);
    endproperty
    property p_no_y6;
        ss |-> (uf_q != pss_pkg::UF_Y6);
    endproperty
    property p_iso_len;
        iso_ss |-> (tok_len <= 10'h0bc)
            && (tok_pos == pss_pkg::POS_END || tok_pos == pss_pkg::POS_ALL || tok_len == 10'h0bc);
    endproperty
    property p_pos_order;
        s_mid_or_end |-> (pos_q == pss_pkg::POS_BEGIN || pos_q == pss_pkg::POS_MID);
    endproperty
    property p_zero_all;
        iso_ss && (tok_pos != pss_pkg::POS_ALL) |-> (tok_len != 10'h000);
    endproperty
    property p_no_cs_iso_out;
        tok_vld && tok_cs |-> (tok_kind != pss_pkg::KIND_ISO_OUT);
    endproperty

    a_ss_ack: assert property (p_ss_ack) else $error("start-split not acknowledged");
    a_uf_num: assert property (p_uf_num) else $error("frame number change off microframe zero");
    a_window: assert property (p_window) else $error("token outside its microframe");
    a_no_y6: assert property (p_no_y6) else $error("start-split in microframe six");
    a_iso_len: assert property (p_iso_len) else $error("iso out piece length wrong");
    a_pos_order: assert property (p_pos_order) else $error("iso out position out of order");
    a_zero_all: assert property (p_zero_all) else $error("empty piece not sent as all");
    a_no_cs_iso_out: assert property (p_no_cs_iso_out) else $error("complete-split for iso out");
endmodule : pss_chk

// *** verif/periodic_split_scheduler_tb.sv ***
`timescale 1ns/10ps
module periodic_split_scheduler_tb;
    logic               clock = 1'b0, srst = 1'b1, run = 1'b0, req_vld = 1'b0, hs_err = 1'b0;
    logic               req_ready, busy, done, refused, fs_sof, locked, hs_idle, ss_seen, e_y6, e_many, e_cso;
    pss_pkg::pss_kind_t req_kind = pss_pkg::KIND_INT;
    logic [2:0]         req_start_uf = 3'h0, cur_uf, uframe, last_uf;
    logic [9:0]         req_len = 10'h000, sum_len;
    logic [15:0]        traits = 16'h0000;
    logic [10:0]        frm_q = 11'h000, fs_frame, cur_frame;
    logic               got_done, got_ref, arm = 1'b0, zero_q = 1'b0, seen_q = 1'b0, bad = 1'b0;
    int                 err_count = 0, checked = 0, ss_n, cs_n, fs_n;

    pss_link_if link ();
    pss_host u_pss_host (.clock(clock), .srst(srst), .link(link), .run(run), .req_vld(req_vld),
        .req_ready(req_ready), .req_kind(req_kind), .req_start_uf(req_start_uf), .req_len(req_len),
        .hub_traits_field(traits), .hs_err(hs_err), .busy(busy), .done(done), .refused(refused),
        .cur_frame(cur_frame), .cur_uf(cur_uf));
    // short frame timer so a missed stop shows
    pss_xlat #(.FRAME_CYC(400)) u_pss_xlat (.clock(clock), .srst(srst), .link(link), .fs_sof(fs_sof),
        .fs_frame(fs_frame), .uframe(uframe), .locked(locked), .hs_idle(hs_idle), .ss_seen(ss_seen),
        .err_ss_y6(e_y6), .err_ss_many(e_many), .err_cs_iso_out(e_cso));
    pss_chk u_pss_chk (.clock(clock), .srst(srst), .sof_vld(link.sof_vld), .sof_frame(link.sof_frame),
        .tok_vld(link.tok_vld), .tok_cs(link.tok_cs), .tok_kind(link.tok_kind), .tok_pos(link.tok_pos),
        .tok_len(link.tok_len), .ans_vld(link.ans_vld), .ans_code(link.ans_code));

    always #50 clock = ~clock;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // link watch; hs_err rides the answer to one armed complete-split
    always @(posedge clock)
    begin
        hs_err <= arm && link.tok_vld && link.tok_cs;
        if (arm && link.tok_vld && link.tok_cs)
            arm = 1'b0;
        if (zero_q)
        begin
            check(16'(fs_sof), 16'h0001);
            check(16'(uframe), 16'h0000);
            check(16'(fs_frame), 16'(frm_q));
            check(16'(cur_frame), 16'(frm_q));
        end
        zero_q = link.sof_vld && seen_q && (link.sof_frame !== frm_q);
        if (link.sof_vld)
        begin
            seen_q = 1'b1;
            frm_q = link.sof_frame;
        end
        if (ss_seen)
            ss_n++;
        if (link.tok_vld)
            last_uf = cur_uf;
        if (link.tok_vld && link.tok_cs)
            cs_n++;
        if (link.tok_vld && !link.tok_cs)
            sum_len = sum_len + link.tok_len;
        if (done)
            got_done = 1'b1;
        if (refused)
            got_ref = 1'b1;
        if (fs_sof)
            fs_n++;
        bad = bad | e_y6 | e_many | e_cso;
    end

    // one request; judge counts, bytes, last microframe
    task automatic txn(input pss_pkg::pss_kind_t k, input logic [2:0] st, input logic [9:0] ln,
                       input logic [1:0] th, input logic [15:0] e_ss, input logic [15:0] e_cs,
                       input logic [2:0] e_last);
        int n;
        @(posedge clock);
        ss_n = 0;
        cs_n = 0;
        sum_len = 10'h000;
        got_done = 1'b0;
        traits <= {9'h000, th, 5'h00};
        req_kind <= k;
        req_start_uf <= st;
        req_len <= ln;
        req_vld <= 1'b1;
        do @(posedge clock); while (req_ready !== 1'b1);
        req_vld <= 1'b0;
        n = 0;
        while (got_done !== 1'b1 && n < 25000)
        begin
            @(negedge clock);
            n++;
        end
        check(16'(got_done), 16'h0001);
        check(16'(ss_n), e_ss);
        check(16'(cs_n), e_cs);
        check(16'(sum_len), 16'(ln));
        check(16'(last_uf), 16'(e_last));
        check(16'(bad), 16'h0000);
    endtask : txn

    task automatic t_iso_out;
        txn(pss_pkg::KIND_ISO_OUT, 3'h2, 10'h190, 2'h0, 16'h0003, 16'h0000, 3'h3);
        txn(pss_pkg::KIND_ISO_OUT, 3'h6, 10'h000, 2'h0, 16'h0001, 16'h0000, 3'h5);
        $display("test iso_out finished");
    endtask : t_iso_out

    // start 7 puts its start-split in six
    task automatic t_refuse;
        @(posedge clock);
        got_ref = 1'b0;
        req_start_uf <= 3'h7;
        req_vld <= 1'b1;
        do @(posedge clock); while (req_ready !== 1'b1);
        req_vld <= 1'b0;
        repeat (3) @(negedge clock);
        check(16'(got_ref), 16'h0001);
        check(16'(req_ready), 16'h0001);
        check(16'(busy), 16'h0000);
        $display("test refuse finished");
    endtask : t_refuse

    task automatic t_int;
        txn(pss_pkg::KIND_INT, 3'h0, 10'h008, 2'h0, 16'h0001, 16'h0003, 3'h3);
        txn(pss_pkg::KIND_INT, 3'h6, 10'h008, 2'h0, 16'h0001, 16'h0002, 3'h0);
        $display("test interrupt finished");
    endtask : t_int

    // think code shifts one budget
    task automatic t_iso_in;
        txn(pss_pkg::KIND_ISO_IN, 3'h3, 10'h0af, 2'h0, 16'h0001, 16'h0003, 3'h6);
        txn(pss_pkg::KIND_ISO_IN, 3'h1, 10'h0af, 2'h3, 16'h0001, 16'h0004, 3'h5);
        txn(pss_pkg::KIND_ISO_IN, 3'h0, 10'h3ff, 2'h3, 16'h0001, 16'h0007, 3'h7);
        txn(pss_pkg::KIND_ISO_IN, 3'h5, 10'h064, 2'h3, 16'h0001, 16'h0003, 3'h0);
        txn(pss_pkg::KIND_ISO_IN, 3'h6, 10'h064, 2'h3, 16'h0001, 16'h0002, 3'h0);
        $display("test iso_in finished");
    endtask : t_iso_in

    task automatic t_retry;
        arm = 1'b1;
        txn(pss_pkg::KIND_INT, 3'h2, 10'h008, 2'h0, 16'h0001, 16'h0004, 3'h5);
        $display("test retry finished");
    endtask : t_retry

    // markers stop; frame markers must cease
    task automatic t_idle;
        @(posedge clock);
        check(16'(locked), 16'h0001);
        run <= 1'b0;
        repeat (2510) @(negedge clock);
        check(16'(hs_idle), 16'h0001);
        check(16'(locked), 16'h0000);
        fs_n = 0;
        repeat (900) @(negedge clock);
        check(16'(fs_n), 16'h0000);
        $display("test idle finished");
    endtask : t_idle

    task automatic final_report;
        $display("counts: checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    initial
    begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        run <= 1'b1;
        t_iso_out();
        t_refuse();
        t_int();
        t_iso_in();
        t_retry();
        t_idle();
        final_report();
    end

    // tests take about 92k cycles
    initial
    begin
        repeat (130000) @(posedge clock);
        err_count++;
        final_report();
    end
endmodule : periodic_split_scheduler_tb
